// file: design/clk_supervisor_consts.svh
// Contract
// R1 - flag failure, go limp outside reference window
// R2 - fail flag and limp sticky until power-on
// R3 - external clock is peripheral clock over N
// R4 - bus clock divided by one to sixteen
// R5 - external clock halves stay equal length
// R6 - cpu clock equals system clock one-to-one
// R7 - non-default os timer clock three times slower; no os timer clock is generated here
// R8 - pipeline off keeps system clock below 36; flash_pipeline_o is only stored and limits no clock
// R9 - peripheral clock ordering and 100 MHz ceiling
// R10 - prescale keeps external clock below 80; prescale and bus divider at 0 give the external clock 100 MHz
// R11 - derate clocks when frequency modulation enabled; there is no frequency modulation control and no derating
// R12 - limp changeover without runt pulses
`ifndef CLK_SUPERVISOR_CONSTS_SVH
`define CLK_SUPERVISOR_CONSTS_SVH

`define CS_ADDR_EXTERNAL_CLOCK_OUTPUT_PRESCALE 8'h00
`define CS_ADDR_CLOCK_CTRL 8'h04
`define CS_ADDR_FLASH_READ 8'h08
`define CS_ADDR_STATUS 8'h0c

`define CS_PRESCALE_MSB 15
`define CS_PRESCALE_LSB 0
`define CS_BUSDIV_MSB 19
`define CS_BUSDIV_LSB 16
`define CS_FLASH_PIPE_MSB 2
`define CS_FLASH_PIPE_LSB 0
`define CS_STAT_FAIL_BIT 0
`define CS_STAT_LIMP_BIT 1
`define CS_STAT_SWITCH_BIT 2

`define CS_PRESCALE_RST 16'h0000
`define CS_BUSDIV_RST 4'h0
`define CS_FLASH_PIPE_RST 3'h0

`define CS_RESP_OKAY 2'h0
`define CS_RESP_SLVERR 2'h2

`define CS_CLK_KHZ 200000
`define CS_REF_LOW_KHZ 1500
`define CS_REF_HIGH_KHZ 50000
`define CS_REF_MAX_PERIOD_CYC (`CS_CLK_KHZ / `CS_REF_LOW_KHZ)
`define CS_REF_MIN_PERIOD_CYC ((`CS_CLK_KHZ + `CS_REF_HIGH_KHZ - 1) / `CS_REF_HIGH_KHZ)
`define CS_SWITCH_SETTLE_CYC 4

`endif

// file: design/clk_supervisor_pkg.sv
package clk_supervisor_pkg;

  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_HOLD = 3'h2,
    SW_LIMP = 3'h4
  } switch_state_e;

endpackage : clk_supervisor_pkg

// file: design/half_period_divider.sv
`timescale 1ns/100ps
`default_nettype none

module half_period_divider #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [W-1:0] half_m1_i,
  output logic clk_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_clk;

  // stops only in the low phase, so a stop never cuts a high phase short
  always_comb
  begin
    next_cnt = cnt;
    next_clk = clk_o;
    if (!run_i && !clk_o)
    begin
      next_cnt = '0;
    end
    else if (cnt >= half_m1_i)
    begin
      next_cnt = '0;
      next_clk = ~clk_o; // see R5
    end
    else
    begin
      next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
      clk_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      clk_o <= next_clk;
    end
  end

endmodule : half_period_divider

`default_nettype wire

// file: design/clk_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "clk_supervisor_consts.svh"

module clk_supervisor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reference_clock_input_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic external_clock_output_o,
  output logic peripheral_bus_clk_o,
  output logic cpu_clock_run_o,
  output logic limp_sel_o,
  output logic osc_fail_flag_o,
  output logic [2:0] flash_pipeline_o
);

  // ---------------- register bus ----------------
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [15:0] prescale, next_prescale;
  logic [3:0] busdiv, next_busdiv;
  logic [2:0] next_flash;
  logic switching;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `CS_ADDR_EXTERNAL_CLOCK_OUTPUT_PRESCALE) || (a == `CS_ADDR_CLOCK_CTRL) ||
                 (a == `CS_ADDR_FLASH_READ) || (a == `CS_ADDR_STATUS);
  endfunction : addr_known

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge_lanes = m;
  endfunction : merge_lanes

  function automatic logic [31:0] word_of(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      `CS_ADDR_EXTERNAL_CLOCK_OUTPUT_PRESCALE: w[`CS_PRESCALE_MSB:`CS_PRESCALE_LSB] = prescale;
      `CS_ADDR_CLOCK_CTRL: w[`CS_BUSDIV_MSB:`CS_BUSDIV_LSB] = busdiv;
      `CS_ADDR_FLASH_READ: w[`CS_FLASH_PIPE_MSB:`CS_FLASH_PIPE_LSB] = flash_pipeline_o;
      `CS_ADDR_STATUS:
      begin
        w[`CS_STAT_FAIL_BIT] = osc_fail_flag_o;
        w[`CS_STAT_LIMP_BIT] = limp_sel_o;
        w[`CS_STAT_SWITCH_BIT] = switching;
      end
      default: w = 32'h0;
    endcase
    word_of = w;
  endfunction : word_of

  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = s_axi_awready_o;
    next_wready = s_axi_wready_o;
    next_bvalid = s_axi_bvalid_o;
    next_bresp = s_axi_bresp_o;
    next_arready = s_axi_arready_o;
    next_rvalid = s_axi_rvalid_o;
    next_rresp = s_axi_rresp_o;
    next_rdata = s_axi_rdata_o;
    next_prescale = prescale;
    next_busdiv = busdiv;
    next_flash = flash_pipeline_o;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_awready = 1'b0;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_wready = 1'b0;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (!s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o)
    begin
      merged = merge_lanes(word_of(aw_addr), w_data, w_strb);
      next_bvalid = 1'b1;
      next_bresp = addr_known(aw_addr) ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
      case (aw_addr)
        `CS_ADDR_EXTERNAL_CLOCK_OUTPUT_PRESCALE: next_prescale = merged[`CS_PRESCALE_MSB:`CS_PRESCALE_LSB]; // see R3
        `CS_ADDR_CLOCK_CTRL: next_busdiv = merged[`CS_BUSDIV_MSB:`CS_BUSDIV_LSB]; // see R4
        `CS_ADDR_FLASH_READ: next_flash = merged[`CS_FLASH_PIPE_MSB:`CS_FLASH_PIPE_LSB];
        default: next_flash = flash_pipeline_o;
      endcase
    end
    if (s_axi_bvalid_o && s_axi_bready_i)
    begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = word_of(s_axi_araddr_i);
      next_rresp = addr_known(s_axi_araddr_i) ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
    end
    if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CS_RESP_OKAY;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `CS_RESP_OKAY;
      s_axi_rdata_o <= 32'h0;
      prescale <= `CS_PRESCALE_RST;
      busdiv <= `CS_BUSDIV_RST;
      flash_pipeline_o <= `CS_FLASH_PIPE_RST;
    end
    else
    begin
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o <= next_wready;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rresp_o <= next_rresp;
      s_axi_rdata_o <= next_rdata;
      prescale <= next_prescale;
      busdiv <= next_busdiv;
      flash_pipeline_o <= next_flash;
    end
  end

  // ---------------- reference clock monitor ----------------
  logic ref_s1, ref_s2, ref_s3, ref_level, next_level, armed, next_armed, next_fail;
  logic rise, too_slow, too_fast;
  logic [7:0] per_cnt, next_per_cnt;

  always_comb
  begin
    next_level = (ref_s2 == ref_s3) ? ref_s3 : ref_level;
    rise = ref_s2 && ref_s3 && !ref_level;
    too_slow = (per_cnt == 8'(`CS_REF_MAX_PERIOD_CYC)) && !rise; // see R1
    too_fast = rise && armed && (per_cnt < 8'(`CS_REF_MIN_PERIOD_CYC)); // see R1
    next_armed = armed || rise;
    next_per_cnt = rise ? 8'h00 :
                   (too_slow ? per_cnt : per_cnt + 8'h01);
    next_fail = osc_fail_flag_o || too_slow || too_fast; // see R2
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_level <= 1'b0;
      armed <= 1'b0;
      per_cnt <= 8'h00;
      osc_fail_flag_o <= 1'b0;
    end
    else
    begin
      ref_s1 <= reference_clock_input_i;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ref_level <= next_level;
      armed <= next_armed;
      per_cnt <= next_per_cnt;
      osc_fail_flag_o <= next_fail;
    end
  end

  // ---------------- limp changeover ----------------
  clk_supervisor_pkg::switch_state_e state, next_state;
  logic next_limp, next_run;
  logic [2:0] settle_cnt, next_settle;

  assign switching = (state == clk_supervisor_pkg::SW_HOLD);

  always_comb
  begin
    next_state = state;
    next_limp = limp_sel_o;
    next_settle = settle_cnt;
    case (state)
      clk_supervisor_pkg::SW_RUN:
      begin
        if (osc_fail_flag_o)
        begin
          next_state = clk_supervisor_pkg::SW_HOLD; // see R1
        end
      end
      clk_supervisor_pkg::SW_HOLD:
      begin
        if (!limp_sel_o)
        begin
          if (!external_clock_output_o && !peripheral_bus_clk_o)
          begin
            next_limp = 1'b1; // see R12
          end
        end
        else if (settle_cnt == 3'(`CS_SWITCH_SETTLE_CYC - 1))
        begin
          next_state = clk_supervisor_pkg::SW_LIMP;
        end
        else
        begin
          next_settle = settle_cnt + 3'h1;
        end
      end
      clk_supervisor_pkg::SW_LIMP: next_state = clk_supervisor_pkg::SW_LIMP; // see R2
      default: next_state = clk_supervisor_pkg::SW_RUN;
    endcase
    next_run = (next_state != clk_supervisor_pkg::SW_HOLD); // see R6
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= clk_supervisor_pkg::SW_RUN;
      limp_sel_o <= 1'b0;
      settle_cnt <= 3'h0;
      cpu_clock_run_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      limp_sel_o <= next_limp;
      settle_cnt <= next_settle;
      cpu_clock_run_o <= next_run;
    end
  end

  // ---------------- derived clocks ----------------
  function automatic logic [20:0] external_clock_output_half_m1(input logic [3:0] x_m1,
                                               input logic [15:0] n_m1);
    logic [20:0] x, n, p;
    x = {17'h0, x_m1} + 21'h1;
    n = {5'h0, n_m1} + 21'h1;
    p = 21'(x * n);
    external_clock_output_half_m1 = p - 21'h1;
  endfunction : external_clock_output_half_m1

  logic [20:0] external_clock_output_half;
  assign external_clock_output_half = external_clock_output_half_m1(busdiv, prescale); // see R3

  half_period_divider #(.W(4)) u_bus_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(cpu_clock_run_o),
    .half_m1_i(busdiv),
    .clk_o(peripheral_bus_clk_o)
  );

  half_period_divider #(.W(21)) u_external_clock_output_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(cpu_clock_run_o),
    .half_m1_i(external_clock_output_half),
    .clk_o(external_clock_output_o)
  );

  // ---------------- checks ----------------
  logic external_clock_output_prev, bus_prev;
  logic [20:0] external_clock_output_len_q, external_clock_output_len;
  logic [3:0] bus_len_q, bus_len;

  assign external_clock_output_len = (external_clock_output_o != external_clock_output_prev) ? 21'h0 : external_clock_output_len_q;
  assign bus_len = (peripheral_bus_clk_o != bus_prev) ? 4'h0 : bus_len_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      external_clock_output_prev <= 1'b0;
      bus_prev <= 1'b0;
      external_clock_output_len_q <= 21'h0;
      bus_len_q <= 4'h0;
    end
    else
    begin
      external_clock_output_prev <= external_clock_output_o;
      bus_prev <= peripheral_bus_clk_o;
      external_clock_output_len_q <= cpu_clock_run_o ? external_clock_output_len + 21'h1 : 21'h0;
      bus_len_q <= cpu_clock_run_o ? bus_len + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_gate_off;
    !cpu_clock_run_o [*4];
  endsequence
  sequence s_gate_on;
    cpu_clock_run_o && limp_sel_o;
  endsequence

  property p_slow_ref_fails;
    too_slow |=> osc_fail_flag_o;
  endproperty
  a_slow_ref_fails: assert property (p_slow_ref_fails) else $error("slow reference not flagged"); // see R1
  property p_fast_ref_fails;
    rise && armed && per_cnt < 8'd4 |=> osc_fail_flag_o;
  endproperty
  a_fast_ref_fails: assert property (p_fast_ref_fails) else $error("fast reference not flagged"); // see R1
  property p_fail_sticky;
    osc_fail_flag_o |=> osc_fail_flag_o && state != clk_supervisor_pkg::SW_RUN;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag or limp released"); // see R2
  property p_changeover;
    $rose(limp_sel_o) |-> !external_clock_output_o && !peripheral_bus_clk_o
      ##0 s_gate_off ##1 s_gate_on;
  endproperty
  a_changeover: assert property (p_changeover) else $error("limp changeover sequence broken"); // see R12
  property p_external_clock_output_period;
    rst_n_i && cpu_clock_run_o && $stable(external_clock_output_half) && external_clock_output_len == external_clock_output_half
      |=> external_clock_output_o != $past(external_clock_output_o);
  endproperty
  a_external_clock_output_period: assert property (p_external_clock_output_period) else $error("external clock did not toggle"); // see R3
  property p_bus_period;
    rst_n_i && cpu_clock_run_o && $stable(busdiv) && bus_len == busdiv
      |=> peripheral_bus_clk_o != $past(peripheral_bus_clk_o);
  endproperty
  a_bus_period: assert property (p_bus_period) else $error("bus clock did not toggle"); // see R4
  property p_external_clock_output_duty;
    cpu_clock_run_o && $stable(external_clock_output_half) |-> external_clock_output_len <= external_clock_output_half;
  endproperty
  a_external_clock_output_duty: assert property (p_external_clock_output_duty) else $error("external clock phase too long"); // see R5
  property p_cpu_with_system;
    $rose(cpu_clock_run_o) |-> $past(!external_clock_output_o && !peripheral_bus_clk_o);
  endproperty
  a_cpu_with_system: assert property (p_cpu_with_system) else $error("cpu clock restart misaligned"); // see R6

endmodule : clk_supervisor

`default_nettype wire

// file: verification/ref_osc.sv
`timescale 1ns/100ps
`default_nettype none

// reference oscillator: free running while run_i, frozen otherwise
module ref_osc (
  input wire logic run_i,
  input wire logic [15:0] half_ns_i,
  output logic ref_o
);
  initial
  begin
    ref_o = 1'h0;
    #1.3;
    forever
    begin
      #(half_ns_i);
      if (run_i)
        ref_o = ~ref_o;
    end
  end
endmodule : ref_osc

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic ref_run = 1'h1;
  logic [15:0] ref_half = 16'h0032;
  logic ref_clk;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, external_clock_output, bclk, cpu_run, limp, fail;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [2:0] pipe;
  int miscompares = 0;
  int comparisons = 0;
  int hi, lo, n;

  always #2.5 clk_i = ~clk_i;

  ref_osc ref_osc_i (.run_i(ref_run), .half_ns_i(ref_half), .ref_o(ref_clk));

  clk_supervisor clk_supervisor_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reference_clock_input_i(ref_clk),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .external_clock_output_o(external_clock_output),
    .peripheral_bus_clk_o(bclk), .cpu_clock_run_o(cpu_run), .limp_sel_o(limp),
    .osc_fail_flag_o(fail), .flash_pipeline_o(pipe)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cycles

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (k < 50)
    begin
      @(posedge clk_i);
      k++;
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
        break;
    end
    resp = bresp;
    bready <= 1'h0;
    if (k == 50)
      check(32'h1, 32'h0);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (k < 50)
    begin
      @(posedge clk_i);
      k++;
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
        break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
    if (k == 50)
      check(32'h1, 32'h0);
  endtask : rd_reg

  function automatic logic lvl(input logic e);
    return e ? external_clock_output : bclk;
  endfunction : lvl

  // lengths of one high and the following low phase, in clk cycles
  task automatic phases(input logic e);
    hi = 0;
    lo = 0;
    n = 0;
    while (lvl(e) !== 1'h0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    while (lvl(e) !== 1'h1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    while (lvl(e) === 1'h1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
      hi++;
    end
    while (lvl(e) === 1'h0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
      lo++;
    end
  endtask : phases

  task automatic wait_flag;
    n = 0;
    while (fail !== 1'h1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_flag

  initial
  begin
    #300000;
    miscompares++;
    stop_test;
  end

  initial
  begin
    cycles(4);
    rst_n_i <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(8'(i * 4));
      check(rd, 32'h0);
      check(32'(resp), 32'h0);
    end
    $display("test reset values done");
    wr(8'h00, 32'hffff0002);
    check(32'(resp), 32'h0);
    wr(8'h04, 32'hfff1ffff);
    rd_reg(8'h00);
    check(rd, 32'h00000002);
    rd_reg(8'h04);
    check(rd, 32'h00010000);
    cycles(100);
    phases(1'h1);
    check(32'(hi), 32'h6);
    check(32'(lo), 32'h6);
    phases(1'h0);
    check(32'(hi), 32'h2);
    check(32'(lo), 32'h2);
    wr(8'h04, 32'h000f0000);
    wr(8'h00, 32'h0);
    cycles(200);
    phases(1'h1);
    check(32'(hi), 32'h10);
    check(32'(lo), 32'h10);
    phases(1'h0);
    check(32'(hi), 32'h10);
    $display("test dividers done");
    wr(8'h08, 32'hfffffffd);
    check(32'(pipe), 32'h5);
    rd_reg(8'h08);
    check(rd, 32'h5);
    rd_reg(8'h40);
    check(32'(resp), 32'h2);
    check(rd, 32'h0);
    wr(8'h40, 32'h1);
    check(32'(resp), 32'h2);
    wr(8'h0c, 32'hffffffff);
    rd_reg(8'h0c);
    check(rd, 32'h0);
    wstrb <= 4'h2;
    wr(8'h00, 32'hffffabff);
    wstrb <= 4'hf;
    rd_reg(8'h00);
    check(rd, 32'h0000ab00);
    wr(8'h00, 32'h0);
    n = 0;
    repeat (200)
    begin
      @(posedge clk_i);
      if (cpu_run !== 1'h1)
        n++;
    end
    check(32'(n), 32'h0);
    $display("test registers done");
    ref_run <= 1'h0;
    wait_flag();
    check(32'(fail), 32'h1);
    n = 0;
    while (limp !== 1'h1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    check(32'(limp), 32'h1);
    check(32'({external_clock_output, bclk}), 32'h0);
    n = 0;
    while (cpu_run === 1'h0 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    check(32'(n), 32'h4);
    ref_run <= 1'h1;
    cycles(300);
    check(32'({limp, fail}), 32'h3);
    rd_reg(8'h0c);
    check(rd, 32'h3);
    $display("test slow reference done");
    rst_n_i <= 1'h0;
    cycles(4);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    check(32'({limp, fail}), 32'h0);
    cycles(100);
    check(32'(fail), 32'h0);
    ref_half <= 16'h000a;
    wait_flag();
    check(32'(fail), 32'h1);
    $display("test fast reference done");
    stop_test;
  end
endmodule : testbench

`default_nettype wire
